// ===== oag_pkg.sv
// package for the operand address generator: opcode fields, prefixes, modes
package oag_pkg;
    // prefix bytes
    localparam logic [7:0] PFX_Y_INDEX = 8'h90; // y_index_prefix
    localparam logic [7:0] PFX_INDIRECT = 8'h92; // indirect_prefix
    localparam logic [7:0] PFX_Y_INDIRECT = 8'h91; // y_indirect_prefix
    // opcode high nibble groups (column of the opcode map)
    localparam logic [3:0] COL_REL = 4'h2;
    localparam logic [3:0] COL_RMW_DIR = 4'h3;
    localparam logic [3:0] COL_RMW_IX1 = 4'h6;
    localparam logic [3:0] COL_RMW_IX = 4'h7;
    localparam logic [3:0] COL_IMM = 4'hA;
    localparam logic [3:0] COL_DIR = 4'hB;
    localparam logic [3:0] COL_EXT = 4'hC;
    localparam logic [3:0] COL_IX2 = 4'hD;
    localparam logic [3:0] COL_IX1 = 4'hE;
    localparam logic [3:0] COL_IX = 4'hF;
    localparam logic [3:0] COL_BTJ = 4'h0;
    localparam logic [3:0] COL_BSET = 4'h1;
    // zero page ceiling and mode and class counts
    localparam logic [15:0] PAGE0_MASK = 16'h00FF;
    localparam int MODE_COUNT = 17;
    localparam int CLASS_COUNT = 7;

    // seventeen addressing modes
    typedef enum logic [4:0] {
        AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IX0, AM_IX_S, AM_IX_L,
        AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL, AM_REL_IND,
        AM_BIT, AM_BIT_IND, AM_BIT_REL, AM_BIT_REL_IND
    } oag_mode_e;

    // seven classes
    typedef enum logic [2:0] {
        CL_INHERENT, CL_IMMEDIATE, CL_DIRECT, CL_INDEXED, CL_INDIRECT, CL_RELATIVE, CL_BIT
    } oag_class_e;
endpackage : oag_pkg

// ===== oag_operand_address_generator.sv
// operand address generator: decodes addressing mode, fetches operands, forms effective address
// How it works
// - inherent instructions are one byte, two with a prefix; no operand fetch.
// - immediate takes one following byte as the operand value itself.
// - short direct uses one address byte; address stays within 00..FF.
// - long direct uses a two-byte address anywhere in 64 Kbyte.
// - indexed address is unsigned sum of X or Y with offset.
// - no-offset indexed fetches nothing; address is the index register, 00..FF.
// - no-offset indexed length adds zero with X, one (prefix) with Y.
// - short indexed fetches one offset byte; sum reaches up to 1FE.
// - long indexed fetches a two-byte offset covering 64 Kbyte.
// - indirect modes read a pointer at the page-zero address held in the byte after the opcode.
// - short indirect: one pointer-address byte, one-byte pointer, page zero only.
// - long indirect: one pointer-address byte, two-byte pointer, full space.
// - relative target is next-instruction PC plus signed displacement.
// - short direct and short indirect forms address page zero only, 0000h..00FFh.
// - read-modify-write memory instructions decode only with short forms.
// - long forms reach 64 Kbyte with extra bytes and cycles.
// - seventeen addressing modes in seven classes are reported.
// - indirect indexed adds index register to pointer read from memory.
// - prefix 90 swaps X for Y on immediate, direct, indexed, inherent.
// - prefix 92 turns direct, bit, relative and offset X-indexed forms indirect.
// - prefix 91 turns X indirect indexed into Y indirect indexed.
`timescale 1ns/1ps
module oag_operand_address_generator (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // instruction start from the core
    input wire logic start,
    input wire logic [15:0] start_pc,
    // index registers
    input wire logic [7:0] x_reg,
    input wire logic [7:0] y_reg,
    // memory read port
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // results
    output logic busy,
    output logic done,
    output logic illegal,
    output logic [7:0] opcode,
    output logic [7:0] prefix,
    output oag_pkg::oag_mode_e mode,
    output oag_pkg::oag_class_e mode_class,
    output logic use_y,
    output logic [15:0] ea,
    output logic [7:0] imm_value,
    output logic [15:0] branch_target,
    output logic has_branch,
    output logic [2:0] length,
    output logic [15:0] next_pc
);
    import oag_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPC, ST_OP1, ST_OP2, ST_PTR1, ST_PTR2, ST_DISP, ST_DONE
    } oag_state_e;

    oag_state_e state_q, state_d;
    logic [15:0] pc_q;
    logic [7:0] pfx_q;
    logic [7:0] opc_q;
    logic [7:0] b1_q, b2_q, p1_q, p2_q, disp_q;
    logic [2:0] len_q;

    // decode of the current opcode and prefix
    wire [3:0] col = opc_q[7:4];
    wire is_pfx_rd = (mem_rdata == PFX_Y_INDEX) || (mem_rdata == PFX_INDIRECT) || (mem_rdata == PFX_Y_INDIRECT);
    wire p_y = (pfx_q == PFX_Y_INDEX);
    wire p_ind = (pfx_q == PFX_INDIRECT) || (pfx_q == PFX_Y_INDIRECT);
    wire p_yi = (pfx_q == PFX_Y_INDIRECT);
    wire col_ix_any = (col == COL_IX) || (col == COL_IX1) || (col == COL_IX2) ||
                      (col == COL_RMW_IX) || (col == COL_RMW_IX1);
    wire yi_bad = p_yi && !((col == COL_IX1) || (col == COL_RMW_IX1) || (col == COL_IX2));
    // long forms of read-modify-write columns do not exist; long indexed rmw in 91/92 stays short
    wire rmw_col = (col == COL_RMW_DIR) || (col == COL_RMW_IX1) || (col == COL_RMW_IX);

    oag_mode_e dmode;
    always_comb begin
        dmode = AM_INH;
        case (col)
            COL_BTJ: dmode = p_ind ? AM_BIT_REL_IND : AM_BIT_REL;
            COL_BSET: dmode = p_ind ? AM_BIT_IND : AM_BIT;
            COL_REL: dmode = p_ind ? AM_REL_IND : AM_REL;
            COL_RMW_DIR: dmode = p_ind ? AM_IND_S : AM_DIR_S;
            COL_RMW_IX1: dmode = p_ind ? AM_IIX_S : AM_IX_S;
            COL_RMW_IX: dmode = AM_IX0;
            COL_IMM: dmode = AM_IMM;
            COL_DIR: dmode = p_ind ? AM_IND_S : AM_DIR_S;
            COL_EXT: dmode = p_ind ? AM_IND_L : AM_DIR_L;
            COL_IX2: dmode = p_ind ? AM_IIX_L : AM_IX_L;
            COL_IX1: dmode = p_ind ? AM_IIX_S : AM_IX_S;
            COL_IX: dmode = AM_IX0;
            default: dmode = AM_INH;
        endcase
    end

    wire m_ind = (dmode == AM_IND_S) || (dmode == AM_IND_L) || (dmode == AM_IIX_S) || (dmode == AM_IIX_L) ||
                 (dmode == AM_REL_IND) || (dmode == AM_BIT_IND) || (dmode == AM_BIT_REL_IND);
    wire m_ptr_word = (dmode == AM_IND_L) || (dmode == AM_IIX_L);
    wire m_two = (dmode == AM_DIR_L) || (dmode == AM_IX_L);
    wire m_none = (dmode == AM_INH) || (dmode == AM_IX0);
    wire m_disp = (dmode == AM_BIT_REL) || (dmode == AM_BIT_REL_IND);
    wire m_rel = (dmode == AM_REL) || (dmode == AM_REL_IND) || m_disp;
    // 92 on the no-offset or immediate column or off the indirect-capable columns, 91 off the offset-indexed columns are undefined
    wire m_bad = (p_ind && (col == COL_IX || col == COL_RMW_IX || col == COL_IMM)) || yi_bad ||
                 (p_ind && !col_ix_any && !(col inside {COL_BTJ, COL_BSET, COL_REL, COL_RMW_DIR, COL_DIR, COL_EXT})) ||
                 (rmw_col && (m_two || m_ptr_word));
    wire y_sel = p_y || p_yi;

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (start) state_d = ST_OPC;
            ST_OPC: if (mem_ack && !is_pfx_rd) state_d = ST_OP1;
            ST_OP1: begin
                if (m_none) state_d = ST_DONE;
                else if (mem_ack) begin
                    if (m_two) state_d = ST_OP2;
                    else if (m_ind) state_d = ST_PTR1;
                    else if (m_disp) state_d = ST_DISP;
                    else state_d = ST_DONE;
                end
            end
            ST_OP2: if (mem_ack) state_d = ST_DONE;
            ST_PTR1: if (mem_ack) state_d = m_ptr_word ? ST_PTR2 : (m_disp ? ST_DISP : ST_DONE);
            ST_PTR2: if (mem_ack) state_d = ST_DONE;
            ST_DISP: if (mem_ack) state_d = ST_DONE;
            ST_DONE: state_d = start ? ST_OPC : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // memory address: program bytes in sequence, pointer bytes from the pointer address
    wire [15:0] ptr_lo_addr = {8'h00, b1_q} + 16'h0001;
    always_comb begin
        mem_addr = pc_q;
        case (state_q)
            ST_PTR1: mem_addr = {8'h00, b1_q};
            ST_PTR2: mem_addr = ptr_lo_addr;
            default: mem_addr = pc_q;
        endcase
    end
    assign mem_req = (state_q == ST_OPC) || (state_q == ST_OP2) || (state_q == ST_PTR1) ||
                     (state_q == ST_PTR2) || (state_q == ST_DISP) || ((state_q == ST_OP1) && !m_none);
    assign busy = (state_q != ST_IDLE) && (state_q != ST_DONE);

    // register captures
    // start is taken only between instructions; a start while busy is ignored
    wire take_start = ((state_q == ST_IDLE) || (state_q == ST_DONE)) && start;
    wire rd_ok = mem_req && mem_ack;
    wire prog_rd = rd_ok && (state_q != ST_PTR1) && (state_q != ST_PTR2);
    wire cap_pfx = rd_ok && (state_q == ST_OPC) && is_pfx_rd;
    wire cap_opc = rd_ok && (state_q == ST_OPC) && !is_pfx_rd;
    wire cap_b1 = rd_ok && (state_q == ST_OP1);
    wire cap_b2 = rd_ok && (state_q == ST_OP2);
    wire cap_p1 = rd_ok && (state_q == ST_PTR1);
    wire cap_p2 = rd_ok && (state_q == ST_PTR2);
    wire cap_disp = rd_ok && (state_q == ST_DISP);

    // the final byte is still on the bus when results load, so it is taken from there
    wire [7:0] b1_c = cap_b1 ? mem_rdata : b1_q;
    wire [7:0] b2_c = cap_b2 ? mem_rdata : b2_q;
    wire [7:0] p1_c = cap_p1 ? mem_rdata : p1_q;
    wire [7:0] p2_c = cap_p2 ? mem_rdata : p2_q;
    wire [7:0] dsp_c = cap_disp ? mem_rdata : disp_q;
    // pc after this cycle's read; relative targets count from the next instruction
    wire [15:0] pc_nx = prog_rd ? (pc_q + 16'h0001) : pc_q;

    // state, program counter and length
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
            pc_q <= 16'h0000;
            len_q <= 3'h0;
        end else begin
            state_q <= state_d;
            if (take_start) begin
                pc_q <= start_pc;
                len_q <= 3'h0;
            end else if (prog_rd) begin
                pc_q <= pc_q + 16'h0001;
                len_q <= len_q + 3'h1;
            end
        end
    end

    // prefix cleared at each start so an old prefix never reaches the next opcode
    always_ff @(posedge clock) begin
        if (rst) begin
            pfx_q <= 8'h00;
        end else if (take_start) begin
            pfx_q <= 8'h00;
        end else if (cap_pfx) begin
            pfx_q <= mem_rdata;
        end
    end

    // opcode kept until the next one lands, so decode stays steady through operand reads
    always_ff @(posedge clock) begin
        if (rst) begin
            opc_q <= 8'h00;
        end else if (cap_opc) begin
            opc_q <= mem_rdata;
        end
    end

    // operand and pointer bytes
    always_ff @(posedge clock) begin
        if (rst) begin
            b1_q <= 8'h00;
        end else if (cap_b1) begin
            b1_q <= mem_rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            b2_q <= 8'h00;
        end else if (cap_b2) begin
            b2_q <= mem_rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            p1_q <= 8'h00;
        end else if (cap_p1) begin
            p1_q <= mem_rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            p2_q <= 8'h00;
        end else if (cap_p2) begin
            p2_q <= mem_rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            disp_q <= 8'h00;
        end else if (cap_disp) begin
            disp_q <= mem_rdata;
        end
    end

    // effective address formation
    wire [7:0] idx = y_sel ? y_reg : x_reg;
    wire [15:0] idx16 = {8'h00, idx};
    wire [15:0] word12 = {b1_c, b2_c};
    wire [15:0] ptr16 = m_ptr_word ? {p1_c, p2_c} : {8'h00, p1_c};
    logic [15:0] ea_c;
    always_comb begin
        ea_c = 16'h0000;
        case (dmode)
            AM_DIR_S, AM_BIT, AM_BIT_REL: ea_c = {8'h00, b1_c} & PAGE0_MASK;
            AM_DIR_L: ea_c = word12;
            AM_IX0: ea_c = idx16;
            AM_IX_S: ea_c = idx16 + {8'h00, b1_c};
            AM_IX_L: ea_c = idx16 + word12;
            AM_IND_S, AM_IND_L, AM_BIT_IND, AM_BIT_REL_IND: ea_c = ptr16;
            AM_IIX_S, AM_IIX_L: ea_c = idx16 + ptr16;
            default: ea_c = 16'h0000;
        endcase
    end

    // relative target from the pc of the next instruction
    wire [7:0] disp_c = (dmode == AM_REL) ? b1_c : (dmode == AM_REL_IND ? p1_c : dsp_c);
    wire [15:0] tgt_c = pc_nx + {{8{disp_c[7]}}, disp_c};

    oag_class_e cls_c;
    always_comb begin
        cls_c = CL_INHERENT;
        case (dmode)
            AM_INH: cls_c = CL_INHERENT;
            AM_IMM: cls_c = CL_IMMEDIATE;
            AM_DIR_S, AM_DIR_L: cls_c = CL_DIRECT;
            AM_IX0, AM_IX_S, AM_IX_L: cls_c = CL_INDEXED;
            AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L: cls_c = CL_INDIRECT;
            AM_REL, AM_REL_IND: cls_c = CL_RELATIVE;
            default: cls_c = CL_BIT;
        endcase
    end

    // results held in flops, updated as the instruction completes
    wire finish = (state_q != ST_DONE) && (state_d == ST_DONE);
    wire [2:0] len_fin = (state_q == ST_OP1 && m_none) ? len_q : len_q + ((mem_ack && state_q != ST_PTR1 &&
                         state_q != ST_PTR2) ? 3'h1 : 3'h0);
    // done stands one cycle; a new start may already land in it
    always_ff @(posedge clock) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= finish;
        end
    end

    // decode results
    always_ff @(posedge clock) begin
        if (rst) begin
            illegal <= 1'b0;
            opcode <= 8'h00;
            prefix <= 8'h00;
            mode <= AM_INH;
            mode_class <= CL_INHERENT;
            use_y <= 1'b0;
            length <= 3'h0;
        end else if (finish) begin
            illegal <= m_bad;
            opcode <= opc_q;
            prefix <= pfx_q;
            mode <= dmode;
            mode_class <= cls_c;
            use_y <= y_sel;
            length <= len_fin;
        end
    end

    // address results
    always_ff @(posedge clock) begin
        if (rst) begin
            ea <= 16'h0000;
            imm_value <= 8'h00;
            branch_target <= 16'h0000;
            has_branch <= 1'b0;
            next_pc <= 16'h0000;
        end else if (finish) begin
            ea <= ea_c;
            imm_value <= (dmode == AM_IMM) ? b1_c : 8'h00;
            has_branch <= m_rel;
            next_pc <= pc_nx;
            branch_target <= tgt_c;
        end
    end
endmodule : oag_operand_address_generator

// ===== oag_asserts.sv
// port-level checks for the operand address generator
`timescale 1ns/1ps
module oag_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // start and memory port
    input wire logic start,
    input wire logic [15:0] start_pc,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    // results
    input wire logic busy,
    input wire logic done,
    input wire logic [7:0] prefix,
    input wire oag_pkg::oag_mode_e mode,
    input wire logic use_y,
    input wire logic [15:0] ea,
    input wire logic [2:0] length,
    input wire logic [15:0] next_pc
);
    import oag_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // start address of the instruction in flight, so next_pc can be judged
    logic [15:0] pc_q;
    always_ff @(posedge clock) begin
        if (start && !busy) begin
            pc_q <= start_pc;
        end
    end
    a_first_fetch: assert property (start && !busy |=> mem_req && mem_addr == $past(start_pc))
        else $error("first fetch not at start address");
    a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("read request changed before ack");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_next_pc_len: assert property (done |-> next_pc == pc_q + 16'(length))
        else $error("next pc disagrees with length");
    a_inherent_len: assert property (done && mode == AM_INH && prefix == 8'h00 |-> length == 3'h1)
        else $error("inherent length wrong");
    a_immediate_len: assert property (done && mode == AM_IMM && prefix == 8'h00 |-> length == 3'h2)
        else $error("immediate length wrong");
    a_noofs_index: assert property (done && mode == AM_IX0 |-> ea[15:8] == 8'h00
        && length == (use_y ? 3'h2 : 3'h1))
        else $error("no offset indexed wrong");
    a_short_page: assert property (done && (mode == AM_DIR_S || mode == AM_IND_S) |-> ea[15:8] == 8'h00)
        else $error("short form left page zero");
    a_short_index: assert property (done && mode == AM_IX_S |-> ea <= 16'h01FE)
        else $error("short indexed out of range");
    a_y_prefix: assert property (done && (prefix == PFX_Y_INDEX || prefix == PFX_Y_INDIRECT) |-> use_y)
        else $error("y prefix ignored");
    c_long_ind: cover property (done && mode == AM_IND_L);
    c_wait: cover property (mem_req && !mem_ack);
    c_y_used: cover property (done && use_y);
    c_bit_rel: cover property (done && mode == AM_BIT_REL_IND);
endmodule : oag_asserts
bind oag_operand_address_generator oag_asserts oag_asserts_inst (.clock(clock), .rst(rst), .start(start),
    .start_pc(start_pc), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .busy(busy), .done(done),
    .prefix(prefix), .mode(mode), .use_y(use_y), .ea(ea), .length(length), .next_pc(next_pc));

// ===== oag_mem_model.sv
// behavioural program and data memory answering byte reads
`timescale 1ns/1ps
module oag_mem_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // read port
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    // two wait states per read when set
    input wire logic slow
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic [1:0] wait_q;
    assign mem_ack = mem_req && (!slow || wait_q == 2'h2);
    // outside an answer the bus shows the inverse of the last byte, so stale data never passes
    assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_q;
    always_ff @(posedge clock) begin
        wait_q <= (rst || !mem_req || mem_ack) ? 2'h0 : wait_q + 2'h1;
        last_q <= rst ? 8'h00 : (mem_ack ? mem[mem_addr] : last_q);
    end
endmodule : oag_mem_model

// ===== tb_top.sv
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
    import oag_pkg::*;
    logic clock = 1'b0;
    logic rst, start, slow, mem_req, mem_ack, busy, done, illegal, use_y, has_branch;
    logic [15:0] start_pc, mem_addr, ea, branch_target, next_pc;
    logic [7:0] x_reg, y_reg, mem_rdata, opcode, prefix, imm_value;
    logic [2:0] length;
    oag_mode_e mode;
    oag_class_e mode_class;
    int n_fail = 0;
    int compares = 0;
    always #10 clock = ~clock;
    oag_operand_address_generator oag_operand_address_generator_inst (.clock(clock), .rst(rst), .start(start),
        .start_pc(start_pc), .x_reg(x_reg), .y_reg(y_reg), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done), .illegal(illegal), .opcode(opcode),
        .prefix(prefix), .mode(mode), .mode_class(mode_class), .use_y(use_y), .ea(ea), .imm_value(imm_value),
        .branch_target(branch_target), .has_branch(has_branch), .length(length), .next_pc(next_pc));
    oag_mem_model oag_mem_model_inst (.clock(clock), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));
    task automatic put3(input logic [15:0] a, input logic [7:0] b0, b1, b2);
        oag_mem_model_inst.mem[a] = b0;
        oag_mem_model_inst.mem[a + 16'h0001] = b1;
        oag_mem_model_inst.mem[a + 16'h0002] = b2;
    endtask : put3
    // entered and left just after a rising edge; a new start may land in the done cycle
    task automatic run(input logic [15:0] pc, input logic [7:0] x, y);
        int k;
        start = 1'b1;
        start_pc = pc;
        x_reg = x;
        y_reg = y;
        @(posedge clock);
        #1 start = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        `CHK(done, 1'b1)
    endtask : run
    task automatic t_simple;
        put3(16'h0200, 8'h9D, 8'hA6, 8'h55);
        run(16'h0200, 8'h00, 8'h00);
        `CHK({length, next_pc}, {3'h1, 16'h0201})
        `CHK({opcode, prefix, mode_class, illegal}, {8'h9D, 8'h00, CL_INHERENT, 1'b0})
        run(16'h0201, 8'h00, 8'h00);
        `CHK({imm_value, length, ea}, {8'h55, 3'h2, 16'h0000})
    endtask : t_simple
    task automatic t_direct;
        put3(16'h0220, 8'hB6, 8'h80, 8'hC6);
        put3(16'h0223, 8'h10, 8'h00, 8'h00);
        run(16'h0220, 8'h00, 8'h00);
        `CHK({ea, length}, {16'h0080, 3'h2})
        run(16'h0222, 8'h00, 8'h00);
        `CHK({ea, length, next_pc}, {16'h1000, 3'h3, 16'h0225})
    endtask : t_direct
    task automatic t_indexed;
        put3(16'h0240, 8'hF6, 8'h90, 8'hF6);
        put3(16'h0260, 8'h90, 8'hE6, 8'hFF);
        put3(16'h0270, 8'hD6, 8'h12, 8'h34);
        run(16'h0240, 8'hF0, 8'h00);
        `CHK({ea, length}, {16'h00F0, 3'h1})
        run(16'h0241, 8'h00, 8'h33);
        `CHK({ea, length, use_y}, {16'h0033, 3'h2, 1'b1})
        run(16'h0260, 8'h00, 8'hFF);
        `CHK({ea, length}, {16'h01FE, 3'h3})
        run(16'h0270, 8'h10, 8'h00);
        `CHK({ea, length}, {16'h1244, 3'h3})
    endtask : t_indexed
    // long indirect runs against a memory with wait states
    task automatic t_indirect;
        put3(16'h0280, 8'h92, 8'hB6, 8'h40);
        put3(16'h0290, 8'h92, 8'hC6, 8'h50);
        put3(16'h02A0, 8'h91, 8'hE6, 8'h60);
        put3(16'h0040, 8'h77, 8'hAB, 8'hCD);
        put3(16'h0050, 8'hAB, 8'hCD, 8'h00);
        oag_mem_model_inst.mem[16'h0060] = 8'hF0;
        run(16'h0280, 8'h00, 8'h00);
        `CHK({ea, length}, {16'h0077, 3'h3})
        slow = 1'b1;
        run(16'h0290, 8'h00, 8'h00);
        slow = 1'b0;
        `CHK({ea, length}, {16'hABCD, 3'h3})
        `CHK({mode, mode_class}, {AM_IND_L, CL_INDIRECT})
        run(16'h02A0, 8'h00, 8'h20);
        `CHK({ea, use_y}, {16'h0110, 1'b1})
    endtask : t_indirect
    task automatic t_relative;
        put3(16'h0300, 8'h20, 8'h80, 8'h00);
        run(16'h0300, 8'h00, 8'h00);
        `CHK({branch_target, next_pc, has_branch}, {16'h0282, 16'h0302, 1'b1})
        put3(16'h0310, 8'h92, 8'h20, 8'h40);
        run(16'h0310, 8'h00, 8'h00);
        `CHK({mode, branch_target, length}, {AM_REL_IND, 16'h038A, 3'h3})
    endtask : t_relative
    // bit forms, a read-modify-write direct form and an undefined prefix pairing
    task automatic t_bit;
        put3(16'h0320, 8'h01, 8'h10, 8'h05);
        put3(16'h0330, 8'h92, 8'h00, 8'h40);
        put3(16'h0333, 8'hFE, 8'h3C, 8'h20);
        put3(16'h0336, 8'h92, 8'hA6, 8'h00);
        run(16'h0320, 8'h00, 8'h00);
        `CHK({mode, ea, length, branch_target}, {AM_BIT_REL, 16'h0010, 3'h3, 16'h0328})
        run(16'h0330, 8'h00, 8'h00);
        `CHK({mode, ea, length, branch_target}, {AM_BIT_REL_IND, 16'h0077, 3'h4, 16'h0332})
        run(16'h0334, 8'h00, 8'h00);
        `CHK({mode, ea, length}, {AM_DIR_S, 16'h0020, 3'h2})
        run(16'h0336, 8'h00, 8'h00);
        `CHK({illegal, prefix, opcode}, {1'b1, 8'h92, 8'hA6})
    endtask : t_bit
    // a reset between instructions clears busy, mem_req, done, illegal, mode, mode_class, ea, length and next_pc
    task automatic t_reset;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `CHK({busy, mem_req, done, illegal, mode, mode_class, ea, length, next_pc}, '0)
        rst = 1'b0;
    endtask : t_reset
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        rst = 1'b1;
        {start, slow, start_pc, x_reg, y_reg} = '0;
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        t_simple();
        t_direct();
        t_reset();
        t_indexed();
        t_indirect();
        t_relative();
        t_bit();
        final_report();
    end
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
endmodule : tb_top
